/* File: logic/tcs_fmt.sv */
// turns one converted sample into the channel input word and its flags
// purely combinational; the caller registers the results
`timescale 1ns/100ps
module tcs_fmt (
    input wire logic signed [17:0] code, // tenths of deg C or counts
    input wire logic [3:0] range, // channel range code
    input wire tcs_pkg::tcs_cfg_t cfg, // global settings
    input wire logic open, // sensor loop broken
    output logic [15:0] word, // raw_input_word value
    output logic oor, // outside selected range
    output logic bo_flag // burn-out reported
);
    logic signed [17:0] lo;
    logic signed [17:0] hi;
    logic signed [17:0] cc;
    logic signed [21:0] fv;
    logic is_temp;
    logic is_uni;

    always_comb
    begin
        {lo, hi} = tcs_pkg::tcs_limits(range);
        is_temp = range <= tcs_pkg::TCS_TC_C;
        is_uni = range == tcs_pkg::TCS_U39 || range == tcs_pkg::TCS_U156 || range == tcs_pkg::TCS_U1250;
        oor = code < lo || code > hi;
        cc = (code < lo) ? lo : ((code > hi) ? hi : code);
        fv = {{4{cc[17]}}, cc};
        if (is_temp && cfg.fahr)
            fv = fv * tcs_pkg::F_MUL / tcs_pkg::F_DIV + tcs_pkg::F_OFS;
        // temperatures stay in tenths of a degree throughout
        word = fv[15:0];
        if (is_uni && !cfg.res16)
            word = cc[16:1];
        bo_flag = open && cfg.bo_mode != tcs_pkg::TCS_BO_OFF;
        if (bo_flag)
        begin
            if (cfg.bo_mode == tcs_pkg::TCS_BO_LOW)
                word = is_uni ? tcs_pkg::WORD_UMIN : tcs_pkg::WORD_SMIN;
            else
                word = is_uni ? (cfg.res16 ? tcs_pkg::WORD_UMAX : tcs_pkg::WORD_SMAX) : tcs_pkg::WORD_SMAX;
        end
    end
endmodule // tcs_fmt

/* File: logic/tcs_pkg.sv */
// shared constants, types and range table for the thermocouple status block
// assumes an AHB-Lite fabric and a converter front end on the same clock
package tcs_pkg;

    // ==================== register map ====================
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] CONFIG_OFS = 8'h04;
    localparam logic [7:0] RANGE_OFS = 8'h08;
    localparam logic [7:0] RAW_OFS = 8'h20;
    localparam int NCH = 8;

    // ==================== field layout ====================
    localparam int ST_SELFTEST = 0;
    localparam int ST_NOPWR = 1;
    localparam int ST_DNV = 2;
    localparam int CFG_CNT_LSB = 0;
    localparam int CFG_FAHR = 4;
    localparam int CFG_BO_LSB = 8;
    localparam int CFG_RES16 = 12;
    localparam logic [31:0] CFG_RESET = 32'h0000_0107;
    localparam logic [31:0] RANGE_RESET = 32'h0000_0000;
    localparam int SYNC_STAGES = 2;

    // ==================== conversion constants ====================
    localparam logic signed [21:0] F_MUL = 22'sh000009;
    localparam logic signed [21:0] F_DIV = 22'sh000005;
    localparam logic signed [21:0] F_OFS = 22'sh000140;
    localparam logic [15:0] WORD_SMIN = 16'h8000;
    localparam logic [15:0] WORD_SMAX = 16'h7FFF;
    localparam logic [15:0] WORD_UMIN = 16'h0000;
    localparam logic [15:0] WORD_UMAX = 16'hFFFF;

    typedef enum logic [1:0] {
        TCS_BO_LOW = 2'h0,
        TCS_BO_HIGH = 2'h1,
        TCS_BO_OFF = 2'h2
    } tcs_bo_t;

    typedef enum logic [3:0] {
        TCS_TC_J = 4'h0, TCS_TC_E = 4'h1, TCS_TC_K = 4'h2, TCS_TC_R = 4'h3,
        TCS_TC_S = 4'h4, TCS_TC_T = 4'h5, TCS_TC_B = 4'h6, TCS_TC_N = 4'h7,
        TCS_TC_C = 4'h8, TCS_U39 = 4'h9, TCS_B39 = 4'hA, TCS_B78 = 4'hB,
        TCS_U156 = 4'hC, TCS_B156 = 4'hD, TCS_U1250 = 4'hE
    } tcs_range_t;

    typedef struct packed {
        logic [2:0] chan;
        logic signed [17:0] code;
    } tcs_sample_t;

    typedef struct packed {
        logic res16;
        logic fahr;
        logic [1:0] bo_mode;
        logic [2:0] last_chan;
    } tcs_cfg_t;

    // limits in tenths of a degree C, or in counts for voltage spans
    function automatic logic signed [35:0] tcs_limits(input logic [3:0] r);
        unique case (r)
            TCS_TC_J: tcs_limits = {-18'sd1900, 18'sd7600};
            TCS_TC_E: tcs_limits = {-18'sd2100, 18'sd10000};
            TCS_TC_K: tcs_limits = {-18'sd1500, 18'sd13720};
            TCS_TC_R, TCS_TC_S, TCS_TC_C: tcs_limits = {18'sd650, (r == TCS_TC_C) ? 18'sd23200 : 18'sd17680};
            TCS_TC_T: tcs_limits = {-18'sd2300, 18'sd4000};
            TCS_TC_B: tcs_limits = {18'sd5290, 18'sd18200};
            TCS_TC_N: tcs_limits = {-18'sd700, 18'sd13000};
            TCS_B39, TCS_B78, TCS_B156: tcs_limits = {-18'sd32768, 18'sd32767};
            default: tcs_limits = {18'sd0, 18'sd65535};
        endcase
    endfunction

endpackage

/* File: logic/tcs_sync.sv */
// two-stage level synchroniser for pins arriving from outside hclk
// assumes each bit is a slow level; no bus coherence between bits
`timescale 1ns/100ps
module tcs_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // async reset, active low
    input wire logic [W-1:0] d, // raw pin levels
    output logic [W-1:0] q // synchronised levels
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_reg <= RST;
            q <= RST;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // tcs_sync

/* File: logic/tcs_top.sv */
// status area, settings and input words of the eight-channel thermocouple input
// assumes an AHB-Lite master on hclk and a converter front end on the same clock
`timescale 1ns/100ps
module tcs_top (
    input wire logic hclk, // bus clock, 100 MHz
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // only words used
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic sample_valid, // one-cycle sample strobe
    input wire tcs_pkg::tcs_sample_t sample, // channel and converted code
    input wire logic [7:0] sensor_open_pin, // per-channel open loop pins
    input wire logic field_power_ok_pin, // external field supply present
    input wire logic self_test_fail_pin, // internal self-test failed
    output tcs_pkg::tcs_cfg_t cfg_o, // settings to the front end
    output logic [31:0] range_o // four-bit range per channel
);
    localparam int NCH = tcs_pkg::NCH;

    // ==================== pin synchronisers ====================
    logic [9:0] pins_sync;

    // power-good idles high; a low reset value would flag missing supply after reset
    tcs_sync #(.W(10), .RST(10'h100)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({self_test_fail_pin, field_power_ok_pin, sensor_open_pin}),
        .q(pins_sync)
    );

    // ==================== bus slave ====================
    logic ahb_go;
    logic wr_q;
    logic rd_q;
    logic [7:0] addr_q;
    logic [31:0] hrdata_reg;
    logic [31:0] cfg_reg;
    logic [31:0] range_reg;
    logic configured_reg;
    logic wr_cfg;
    logic wr_range;

    assign ahb_go = hsel && htrans[1] && hready;
    // reads take one wait state so that a write just before lands first
    assign hreadyout = !rd_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign wr_cfg = wr_q && addr_q == tcs_pkg::CONFIG_OFS;
    assign wr_range = wr_q && addr_q == tcs_pkg::RANGE_OFS;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 8'h00;
        end
        else if (rd_q)
            rd_q <= 1'b0;
        else
        begin
            wr_q <= ahb_go && hwrite;
            rd_q <= ahb_go && !hwrite;
            if (ahb_go)
                addr_q <= {haddr[7:2], 2'b00};
        end
    end

    // ==================== settings ====================
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cfg_reg <= tcs_pkg::CFG_RESET;
        else if (wr_cfg)
            cfg_reg <= hwdata;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            range_reg <= tcs_pkg::RANGE_RESET;
        else if (wr_range)
            range_reg <= hwdata;
    end

    // a range change is only trusted once settings are committed again
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            configured_reg <= 1'b0;
        else if (wr_cfg)
            configured_reg <= 1'b1;
        else if (wr_range)
            configured_reg <= 1'b0;
    end

    assign cfg_o = '{
        res16: cfg_reg[tcs_pkg::CFG_RES16],
        fahr: cfg_reg[tcs_pkg::CFG_FAHR],
        bo_mode: cfg_reg[tcs_pkg::CFG_BO_LSB +: 2],
        last_chan: cfg_reg[tcs_pkg::CFG_CNT_LSB +: 3]
    };
    assign range_o = range_reg;

    // ==================== sample formatting ====================
    logic acc;
    logic [15:0] fmt_word;
    logic fmt_oor;
    logic fmt_bo;
    logic [3:0] cur_range;

    // channels past the count are not converted; stray samples are dropped
    assign acc = sample_valid && sample.chan <= cfg_o.last_chan;
    assign cur_range = range_reg[{sample.chan, 2'b00} +: 4];

    tcs_fmt u_fmt (
        .code(sample.code),
        .range(cur_range),
        .cfg(cfg_o),
        .open(pins_sync[sample.chan]),
        .word(fmt_word),
        .oor(fmt_oor),
        .bo_flag(fmt_bo)
    );

    // ==================== channel flags and words ====================
    logic [7:0] oor_reg;
    logic [7:0] bo_reg;
    logic [15:0] raw_reg [NCH];

    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                oor_reg[i] <= 1'b0;
                bo_reg[i] <= 1'b0;
                raw_reg[i] <= 16'h0000;
            end
            else if (3'(i) > cfg_o.last_chan)
            begin
                oor_reg[i] <= 1'b0;
                bo_reg[i] <= 1'b0;
            end
            else if (acc && sample.chan == 3'(i))
            begin
                oor_reg[i] <= fmt_oor;
                bo_reg[i] <= fmt_bo;
                raw_reg[i] <= fmt_word;
            end
        end
    end

    // ==================== module status ====================
    logic stf_reg;
    logic nopwr_reg;
    logic [23:0] status;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stf_reg <= 1'b0;
            nopwr_reg <= 1'b0;
        end
        else
        begin
            stf_reg <= pins_sync[9];
            nopwr_reg <= !pins_sync[8];
        end
    end

    assign status = {bo_reg, oor_reg, 5'h00, !configured_reg, nopwr_reg, stf_reg};

    // ==================== read data ====================
    function automatic logic [31:0] rd_val(input logic [7:0] a);
        rd_val = 32'h0000_0000;
        if (a == tcs_pkg::STATUS_OFS)
            rd_val = {8'h00, status};
        else if (a == tcs_pkg::CONFIG_OFS)
            rd_val = cfg_reg;
        else if (a == tcs_pkg::RANGE_OFS)
            rd_val = range_reg;
        else if (a[7:5] == tcs_pkg::RAW_OFS[7:5])
            rd_val = {16'h0000, raw_reg[a[4:2]]};
    endfunction

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_reg <= 32'h0000_0000;
        else if (rd_q)
            hrdata_reg <= rd_val(addr_q);
    end

    // ==================== checks ====================
    logic rd_status_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rd_status_q <= 1'b0;
        else
            rd_status_q <= rd_q && addr_q == tcs_pkg::STATUS_OFS;
    end

    status_top_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_status_q |-> hrdata[31:24] == 8'h00 && hrdata[7:3] == 5'h00)
        else $error("status area wider than 24 bits");

    dnv_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_range && !wr_cfg |=> status[tcs_pkg::ST_DNV] ##1 (status[tcs_pkg::ST_DNV] || $past(wr_cfg)))
        else $error("data not valid not raised after range change");

    dnv_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_cfg |=> !status[tcs_pkg::ST_DNV])
        else $error("data not valid not cleared by commit");

    no_power_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !field_power_ok_pin [*4] |-> status[tcs_pkg::ST_NOPWR])
        else $error("missing supply flag not set");

    self_test_a: assert property (@(posedge hclk) disable iff (!hresetn)
        self_test_fail_pin [*4] |-> status[tcs_pkg::ST_SELFTEST])
        else $error("self-test flag not set");

    range_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        acc && fmt_oor |=> oor_reg[$past(sample.chan)])
        else $error("out of range flag missed");

    bo_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        acc && cfg_o.bo_mode == tcs_pkg::TCS_BO_OFF |=> !bo_reg[$past(sample.chan)])
        else $error("burn-out flagged while detection off");

    bo_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
        acc && fmt_bo && cfg_o.bo_mode == tcs_pkg::TCS_BO_HIGH
        |=> raw_reg[$past(sample.chan)][14:0] == 15'h7FFF)
        else $error("burn-out high word wrong");

    skip_chan_a: assert property (@(posedge hclk) disable iff (!hresetn)
        sample_valid && sample.chan > cfg_o.last_chan && !wr_cfg
        |=> raw_reg[$past(sample.chan)] == $past(raw_reg[sample.chan]))
        else $error("disabled channel word changed");

    res15_a: assert property (@(posedge hclk) disable iff (!hresetn)
        acc && !fmt_bo && !cfg_o.res16 && (cur_range == tcs_pkg::TCS_U39 || cur_range == tcs_pkg::TCS_U156)
        |=> raw_reg[$past(sample.chan)][15] == 1'b0)
        else $error("15-bit unipolar word exceeds 32767");

    read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ahb_go && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    write_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ahb_go && hwrite |=> hreadyout)
        else $error("write wait state inserted");

    // ==================== flag and burn-out word checks ====================
    no_power_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        field_power_ok_pin [*4] |-> !status[tcs_pkg::ST_NOPWR])
        else $error("missing supply flag stuck");

    self_test_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !self_test_fail_pin [*4] |-> !status[tcs_pkg::ST_SELFTEST])
        else $error("self-test flag stuck");

    range_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        acc && !fmt_oor |=> !oor_reg[$past(sample.chan)])
        else $error("out of range flag not cleared");

    bo_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        acc && pins_sync[sample.chan] && cfg_o.bo_mode != tcs_pkg::TCS_BO_OFF |=> bo_reg[$past(sample.chan)])
        else $error("burn-out flag missed");

    bo_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
        acc && fmt_bo && cfg_o.bo_mode == tcs_pkg::TCS_BO_LOW
        |=> raw_reg[$past(sample.chan)][14:0] == 15'h0000)
        else $error("burn-out low word wrong");

    // a flag of a channel no longer converted would otherwise go stale
    chan_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> ((oor_reg | bo_reg) >> (4'($past(cfg_o.last_chan)) + 4'h1)) == 8'h00)
        else $error("flag set on disabled channel");

    // ==================== word and status checks ====================
    word_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
        acc |=> raw_reg[$past(sample.chan)] == $past(fmt_word))
        else $error("input word not refreshed");

    res16_word_a: assert property (@(posedge hclk) disable iff (!hresetn)
        acc && !fmt_bo && !fmt_oor && cfg_o.res16 && cur_range == tcs_pkg::TCS_U39
        |=> raw_reg[$past(sample.chan)] == $past(sample.code[15:0]))
        else $error("16-bit unipolar word wrong");

    bipolar_word_a: assert property (@(posedge hclk) disable iff (!hresetn)
        acc && !fmt_bo && !fmt_oor && cur_range == tcs_pkg::TCS_B39
        |=> raw_reg[$past(sample.chan)] == $past(sample.code[15:0]))
        else $error("bipolar word not 16 bits");

    status_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_status_q |-> hrdata[23:0] == $past(status))
        else $error("status bytes misplaced");

    dnv_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !wr_cfg && !wr_range |=> $stable(status[tcs_pkg::ST_DNV]))
        else $error("data not valid changed without a write");

    open_cov_c: cover property (@(posedge hclk) disable iff (!hresetn) acc && fmt_bo);
    oor_cov_c: cover property (@(posedge hclk) disable iff (!hresetn) acc && fmt_oor);
    commit_cov_c: cover property (@(posedge hclk) disable iff (!hresetn) wr_range ##[1:20] wr_cfg);
    status_cov_c: cover property (@(posedge hclk) disable iff (!hresetn) rd_status_q);
    fahr_cov_c: cover property (@(posedge hclk) disable iff (!hresetn) acc && cfg_o.fahr);

endmodule // tcs_top

/* File: sim/tb_top.sv */
// self-checking bench for the thermocouple status block over AHB-Lite
// assumes one slave, so the block's hreadyout closes the ready loop
`timescale 1ns/100ps
module tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic sample_valid;
    tcs_pkg::tcs_sample_t sample;
    logic [7:0] sensor_open_pin;
    logic field_power_ok_pin;
    logic self_test_fail_pin;
    tcs_pkg::tcs_cfg_t cfg_o;
    logic [31:0] range_o;
    int n_mismatch = 0;
    int num_checks = 0;

    always #5 hclk = ~hclk;

    tcs_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .sample_valid(sample_valid), .sample(sample),
        .sensor_open_pin(sensor_open_pin), .field_power_ok_pin(field_power_ok_pin),
        .self_test_fail_pin(self_test_fail_pin), .cfg_o(cfg_o), .range_o(range_o));

    tcs_fe_model fe (.hclk(hclk), .sample_valid(sample_valid), .sample(sample),
        .sensor_open_pin(sensor_open_pin), .field_power_ok_pin(field_power_ok_pin),
        .self_test_fail_pin(self_test_fail_pin));

    // ==================== checking ====================
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ==================== bus master ====================
    // ready and read data are taken at the rising edge, before the slave's own update lands
    task automatic wait_rdy(output logic [31:0] d);
        int k;
        k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && k < 50)
        begin
            k++;
            @(posedge hclk);
        end
        if (k >= 50)
            n_mismatch++;
        d = hrdata;
    endtask

    task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                            output logic [31:0] rd);
        logic [31:0] dummy;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_rdy(dummy);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wr ? wd : 32'h0000_0000;
        wait_rdy(rd);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb_xfer(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] x;
        ahb_xfer(1'b0, a, 32'h0000_0000, x);
        check(x, exp);
        check({31'h0000_0000, hresp}, 32'h0000_0000);
    endtask

    // low half of the channel input word at 0x20 + 4*i
    task automatic word_chk(input int i, input logic [15:0] exp);
        logic [31:0] x;
        ahb_xfer(1'b0, 32'h0000_0020 + 32'(4 * i), 32'h0000_0000, x);
        check({16'h0000, x[15:0]}, {16'h0000, exp});
    endtask

    // host side of the link: linear map of a raw word to engineering units
    function automatic int host_scale(input int raw, input int wmin, input int wmax,
                                      input int emin, input int emax, input logic clamp);
        int v;
        v = emin + (raw - wmin) * (emax - emin) / (wmax - wmin);
        if (clamp && v > emax)
            v = emax;
        if (clamp && v < emin)
            v = emin;
        return v;
    endfunction

    // ==================== scenarios ====================
    initial
    begin
        logic [31:0] x;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (5) @(posedge hclk);
        rd_chk(tcs_pkg::STATUS_OFS, 32'h0000_0004);
        rd_chk(tcs_pkg::CONFIG_OFS, 32'h0000_0107);
        check({25'h000_0000, cfg_o}, 32'h0000_000F);
        wr(tcs_pkg::RANGE_OFS, 32'h0000_0000);
        wr(tcs_pkg::CONFIG_OFS, 32'h0000_0107);
        rd_chk(tcs_pkg::STATUS_OFS, 32'h0000_0000);
        fe.send(3'h2, -18'sd2000);
        rd_chk(tcs_pkg::STATUS_OFS, 32'h0000_0400);
        word_chk(2, 16'hF894);
        fe.send(3'h2, 18'sd1234);
        word_chk(2, 16'h04D2);
        ahb_xfer(1'b0, 32'h0000_0028, 32'h0000_0000, x);
        check(32'(host_scale(int'(x[15:0]), 0, 2000, 0, 100, 1'b0)), 32'h0000_003D);
        check(32'(host_scale(int'(x[15:0]), 0, 1000, 0, 100, 1'b1)), 32'h0000_0064);
        rd_chk(tcs_pkg::STATUS_OFS, 32'h0000_0000);
        // open loop on channel 7: three edges through sync and register
        fe.set_pins(8'h80, 1'b1, 1'b0);
        repeat (4) @(posedge hclk);
        fe.send(3'h7, 18'sd100);
        word_chk(7, 16'h7FFF);
        rd_chk(tcs_pkg::STATUS_OFS, 32'h0080_0000);
        wr(tcs_pkg::CONFIG_OFS, 32'h0000_0007);
        fe.send(3'h7, 18'sd100);
        word_chk(7, 16'h8000);
        wr(tcs_pkg::CONFIG_OFS, 32'h0000_0207);
        fe.send(3'h7, 18'sd100);
        word_chk(7, 16'h0064);
        rd_chk(tcs_pkg::STATUS_OFS, 32'h0000_0000);
        fe.set_pins(8'h00, 1'b1, 1'b0);
        wr(tcs_pkg::CONFIG_OFS, 32'h0000_0217);
        fe.send(3'h0, 18'sd1000);
        @(posedge hclk);
        fe.send(3'h5, 18'sd500);
        word_chk(0, 16'h0848);
        word_chk(5, 16'h04C4);
        check({25'h000_0000, cfg_o}, 32'h0000_0037);
        // four channels only: channel 5 samples are dropped
        wr(tcs_pkg::CONFIG_OFS, 32'h0000_0203);
        fe.send(3'h5, 18'sd700);
        word_chk(5, 16'h04C4);
        wr(tcs_pkg::RANGE_OFS, 32'h0000_0009);
        rd_chk(tcs_pkg::STATUS_OFS, 32'h0000_0004);
        wr(tcs_pkg::CONFIG_OFS, 32'h0000_0203);
        fe.send(3'h0, 18'sd40000);
        word_chk(0, 16'h4E20);
        wr(tcs_pkg::CONFIG_OFS, 32'h0000_1203);
        fe.send(3'h0, 18'sd40000);
        word_chk(0, 16'h9C40);
        wr(tcs_pkg::RANGE_OFS, 32'h0000_000A);
        wr(tcs_pkg::CONFIG_OFS, 32'h0000_0203);
        fe.send(3'h0, -18'sd300);
        word_chk(0, 16'hFED4);
        rd_chk(tcs_pkg::RANGE_OFS, 32'h0000_000A);
        check(range_o, 32'h0000_000A);
        fe.set_pins(8'h00, 1'b0, 1'b1);
        repeat (4) @(posedge hclk);
        rd_chk(tcs_pkg::STATUS_OFS, 32'h0000_0003);
        fe.set_pins(8'h00, 1'b1, 1'b0);
        repeat (4) @(posedge hclk);
        rd_chk(tcs_pkg::STATUS_OFS, 32'h0000_0000);
        // unmapped word and read-only status ignore writes
        wr(32'h0000_001C, 32'hFFFF_FFFF);
        rd_chk(32'h0000_001C, 32'h0000_0000);
        wr(tcs_pkg::STATUS_OFS, 32'h00FF_FFFF);
        rd_chk(tcs_pkg::STATUS_OFS, 32'h0000_0000);
        rd_chk(tcs_pkg::CONFIG_OFS, 32'h0000_0203);
        summarize();
    end

    // whole run is under two hundred cycles; this leaves ample margin
    initial
    begin
        #200000;
        n_mismatch++;
        summarize();
    end
endmodule // tb_top

/* File: sim/tcs_fe_model.sv */
// converter front end and field pins as seen by the status block
// assumes hclk is shared with the block; samples are launched just after a rising edge
`timescale 1ns/100ps
module tcs_fe_model (
    hclk, // bus clock
    sample_valid, // one-cycle sample strobe
    sample, // channel and converted code
    sensor_open_pin, // loop broken per channel
    field_power_ok_pin, // field supply present
    self_test_fail_pin // self-test failed
);
    input wire logic hclk;
    output logic sample_valid;
    output tcs_pkg::tcs_sample_t sample;
    output logic [7:0] sensor_open_pin;
    output logic field_power_ok_pin;
    output logic self_test_fail_pin;

    initial
    begin
        sample_valid = 1'b0;
        sample = '0;
        sensor_open_pin = 8'h00;
        field_power_ok_pin = 1'b1;
        self_test_fail_pin = 1'b0;
    end

    // ==================== conversions ====================
    // one conversion result per call; bus is scrambled outside the strobe
    task automatic send(input logic [2:0] c, input logic signed [17:0] v);
        sample_valid <= 1'b1;
        sample <= '{chan: c, code: v};
        @(posedge hclk);
        sample_valid <= 1'b0;
        sample <= tcs_pkg::tcs_sample_t'(~{c, v});
    endtask

    // ==================== field pins ====================
    task automatic set_pins(input logic [7:0] open, input logic pwr, input logic st);
        sensor_open_pin <= open;
        field_power_ok_pin <= pwr;
        self_test_fail_pin <= st;
    endtask
endmodule // tcs_fe_model
